// File: rtl/flash_self_program_control.sv
`timescale 1ns/100ps
`default_nettype none

module flash_self_program_control
   import self_prog_pkg::*;
#(
   parameter int          WORD_IDX_W    = 7,       // Words per page, log2
   parameter int          PAGE_W        = 9,       // Page number width
   parameter int          ADDR_W        = 24,      // Byte address width
   parameter logic [8:0]  HALT_PAGE     = 9'h1E0,  // First page that halts core
   parameter logic [15:0] BOOT_VECTOR   = 16'hF000 // Boot loader word addr
)(
   input  wire  logic                  core_clk,
   input  wire  logic                  rstn,
   // Avalon-MM slave
   input  wire  logic [3:0]            avs_address,
   input  wire  logic                  avs_read,
   input  wire  logic                  avs_write,
   input  wire  logic [31:0]           avs_writedata,
   input  wire  logic [3:0]            avs_byteenable,
   output logic [31:0]                 avs_readdata,
   output logic                        avs_waitrequest,
   // Processor side
   input  wire  cpu_req_t              cpu_req,
   input  wire  logic                  global_irq_flag,
   input  wire  logic                  boot_reset_fuse,
   input  wire  fuse_bits_t            fuse_bits,
   input  wire  logic [15:0]           flash_rd_word,
   output logic [7:0]                  load_data,
   output logic                        load_valid,
   output logic                        cpu_stall,
   output logic                        ready_irq,
   output logic                        section_read_block,
   output logic [15:0]                 reset_vector,
   // Flash array side
   input  wire  logic                  flash_done,
   input  wire  logic [WORD_IDX_W-1:0] buf_rd_idx,
   output logic [15:0]                 buf_rd_data,
   output logic                        flash_start,
   output logic                        flash_erase,
   output logic [PAGE_W-1:0]           flash_page
);

   localparam int PAGE_WORDS = 1 << WORD_IDX_W;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   seq_state_t             state_reg;        // Sequencer state
   logic [4:0]             cmd_reg;          // Command bits 4..0
   logic                   irq_en_reg;       // Interrupt enable
   logic                   busy_flag_reg;    // Section busy flag
   logic [2:0]             win_cnt_reg;      // Window countdown
   logic [7:0]             lock_reg;         // Boot lock bits
   logic [PAGE_WORDS-1:0]  written_reg;      // Buffer word written
   logic [15:0]            buf_mem [PAGE_WORDS]; // Temporary buffer
   logic                   avs_wait_reg;     // Waitrequest flop
   logic [31:0]            avs_rdata_reg;    // Read data flop
   logic                   vec_done_reg;     // Reset vector caught
   logic                   stall_reg;        // Processor stall
   logic                   irq_reg;          // Ready interrupt
   logic [7:0]             load_data_reg;    // Load result
   logic                   load_valid_reg;   // Load result strobe
   logic [15:0]            vector_reg;       // Reset vector
   logic [15:0]            buf_rd_reg;       // Buffer read port
   logic                   fl_start_reg;     // Flash start pulse
   logic                   fl_erase_reg;     // Flash op is erase
   logic [PAGE_W-1:0]      fl_page_reg;      // Latched page

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic [ADDR_W-1:0]      full_addr;    // Extension and pointer
   logic [PAGE_W-1:0]      req_page;     // Page field
   logic [WORD_IDX_W-1:0]  req_word;     // Word within page
   logic                   ctrl_wr;      // Control write taken
   logic [4:0]             wr_cmd;       // Written command bits
   logic                   store_go;     // Store inside window
   logic                   load_go;      // Lock/fuse load in window
   logic                   reen_wr;      // Legal re-enable write

   // Legal command code check
   function automatic logic cmd_legal(input logic [4:0] c);
      cmd_legal = (c == CMD_LOAD) || (c == CMD_ERASE) ||
                  (c == CMD_WRITE) || (c == CMD_LOCK) || (c == CMD_REEN);
   endfunction

   // Byte of a word picked by pointer bit zero
   function automatic logic [7:0] pick_byte(input logic [15:0] w,
                                            input logic        sel);
      pick_byte = sel ? w[15:8] : w[7:0];
   endfunction

   always_comb begin
      full_addr = {cpu_req.page_ext, cpu_req.zptr};
      // Page field above the word index and byte bit
      req_page  = full_addr[WORD_IDX_W+1 +: PAGE_W];
      // Pointer bit zero ignored for buffer loads
      req_word  = full_addr[1 +: WORD_IDX_W];
      ctrl_wr   = avs_write && !avs_wait_reg &&
                  (avs_address == CTRL_OFFSET) && avs_byteenable[0];
      wr_cmd    = avs_writedata[4:0];
      // Refused while an erase or write runs
      reen_wr   = ctrl_wr && (state_reg != ST_BUSY) &&
                  (wr_cmd == CMD_REEN);
      store_go  = cpu_req.store && (state_reg == ST_ARMED) &&
                  (win_cnt_reg != 3'h0);
      // Load accepted only in first three window cycles
      load_go   = cpu_req.load && (state_reg == ST_ARMED) &&
                  (cmd_reg == CMD_LOCK) &&
                  (win_cnt_reg > (STORE_WINDOW - LOAD_WINDOW));
   end

   // ----------------------------------------------------------------
   // Avalon slave: one wait cycle, then answer
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         avs_wait_reg  <= 1'b1;
         avs_rdata_reg <= 32'h0000_0000;
      end else if ((avs_read || avs_write) && avs_wait_reg) begin
         avs_wait_reg <= 1'b0;
         // Reserved bit reads zero
         unique case (avs_address)
            CTRL_OFFSET: avs_rdata_reg <= {24'h00_0000, irq_en_reg,
                                           busy_flag_reg, 1'b0,
                                           cmd_reg};
            LOCK_OFFSET: avs_rdata_reg <= {24'h00_0000, lock_reg};
            default:     avs_rdata_reg <= 32'h0000_0000;
         endcase
      end else begin
         avs_wait_reg <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Command sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg     <= ST_IDLE;
         cmd_reg       <= CTRL_RESET[4:0];
         irq_en_reg    <= CTRL_RESET[IRQ_EN_BIT];
         busy_flag_reg <= CTRL_RESET[BUSY_BIT];
         win_cnt_reg   <= 3'h0;
         stall_reg     <= 1'b0;
         fl_start_reg  <= 1'b0;
         fl_erase_reg  <= 1'b0;
         fl_page_reg   <= '0;
      end else begin
         fl_start_reg <= 1'b0;
         // Interrupt enable always writable
         if (ctrl_wr) begin
            irq_en_reg <= avs_writedata[IRQ_EN_BIT];
         end
         unique case (state_reg)
            ST_IDLE, ST_ARMED: begin
               if (ctrl_wr && cmd_legal(wr_cmd)) begin
                  // Legal code opens a fresh window
                  cmd_reg     <= wr_cmd;
                  state_reg   <= ST_ARMED;
                  win_cnt_reg <= STORE_WINDOW;
               end else if (store_go) begin
                  unique case (cmd_reg)
                     CMD_ERASE, CMD_WRITE: begin
                        // Address frozen for the whole operation
                        fl_page_reg  <= req_page;
                        fl_erase_reg <= (cmd_reg == CMD_ERASE);
                        fl_start_reg <= 1'b1;
                        state_reg    <= ST_BUSY;
                        win_cnt_reg  <= 3'h0;
                        if (req_page < HALT_PAGE) begin
                           busy_flag_reg <= 1'b1;
                        end else begin
                           stall_reg <= 1'b1;
                        end
                     end
                     CMD_LOAD, CMD_REEN: begin
                        // Either store frees the section
                        busy_flag_reg <= 1'b0;
                        cmd_reg       <= 5'h00;
                        state_reg     <= ST_IDLE;
                        win_cnt_reg   <= 3'h0;
                     end
                     default: begin
                        // Lock set completes at once
                        cmd_reg     <= 5'h00;
                        state_reg   <= ST_IDLE;
                        win_cnt_reg <= 3'h0;
                     end
                  endcase
               end else if (load_go) begin
                  // Lock or fuse read completes the command
                  cmd_reg     <= 5'h00;
                  state_reg   <= ST_IDLE;
                  win_cnt_reg <= 3'h0;
               end else if (win_cnt_reg == 3'h1) begin
                  // Window ran out with no store
                  cmd_reg     <= 5'h00;
                  state_reg   <= ST_IDLE;
                  win_cnt_reg <= 3'h0;
               end else if (win_cnt_reg != 3'h0) begin
                  win_cnt_reg <= win_cnt_reg - 3'h1;
               end
            end
            ST_BUSY: begin
               // Command enable held until the array finishes
               if (flash_done) begin
                  cmd_reg   <= 5'h00;
                  stall_reg <= 1'b0;
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Boot lock bits, programmed only toward zero
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         lock_reg <= LOCK_RESET;
      end else if (store_go && cmd_reg == CMD_LOCK) begin
         // Only low data register used, high and pointer ignored
         lock_reg <= lock_reg & (cpu_req.r0 | ~LOCK_WR_MASK);
      end
   end

   // ----------------------------------------------------------------
   // Temporary page buffer
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         written_reg <= '0;
      end else if (reen_wr ||
                   (state_reg == ST_BUSY && flash_done && !fl_erase_reg))
      begin
         // Loaded words dropped on re-enable or after write
         written_reg <= '0;
      end else if (store_go && cmd_reg == CMD_LOAD) begin
         written_reg[req_word] <= 1'b1;
      end
   end

   // Buffer storage, each word written once between clears
   always_ff @(posedge core_clk) begin
      if (store_go && cmd_reg == CMD_LOAD && !written_reg[req_word]) begin
         buf_mem[req_word] <= {cpu_req.r1, cpu_req.r0};
      end
   end

   // Array read port, unwritten words read erased
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         buf_rd_reg <= BUF_ERASED;
      end else begin
         buf_rd_reg <= written_reg[buf_rd_idx] ? buf_mem[buf_rd_idx]
                                               : BUF_ERASED;
      end
   end

   // ----------------------------------------------------------------
   // Load instruction results
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         load_data_reg  <= 8'h00;
         load_valid_reg <= 1'b0;
      end else begin
         load_valid_reg <= cpu_req.load;
         if (load_go) begin
            // Fuses only read here, never written
            unique case (cpu_req.zptr[1:0])
               2'b00: load_data_reg <= fuse_bits.low;
               2'b01: load_data_reg <= lock_reg;
               2'b10: load_data_reg <= fuse_bits.ext;
               2'b11: load_data_reg <= fuse_bits.high;
               default: load_data_reg <= 8'h00;
            endcase
         end else if (cpu_req.load) begin
            load_data_reg <= pick_byte(flash_rd_word,
                                       cpu_req.zptr[0]);
         end
      end
   end

   // ----------------------------------------------------------------
   // Reset vector, interrupt and status outputs
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         vec_done_reg <= 1'b0;
         vector_reg   <= 16'h0000;
      end else if (!vec_done_reg) begin
         // Fuse caught once after release
         vec_done_reg <= 1'b1;
         vector_reg   <= boot_reset_fuse ? 16'h0000 : BOOT_VECTOR;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= irq_en_reg && global_irq_flag &&
                    (cmd_reg[CMDEN_BIT] == 1'b0);
      end
   end

   assign avs_readdata       = avs_rdata_reg;
   assign avs_waitrequest    = avs_wait_reg;
   assign load_data          = load_data_reg;
   assign load_valid         = load_valid_reg;
   assign cpu_stall          = stall_reg;
   assign ready_irq          = irq_reg;
   assign section_read_block = busy_flag_reg;
   assign reset_vector       = vector_reg;
   assign buf_rd_data        = buf_rd_reg;
   assign flash_start        = fl_start_reg;
   assign flash_erase        = fl_erase_reg;
   assign flash_page         = fl_page_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_irq_follows_idle: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (irq_en_reg && global_irq_flag && !cmd_reg[0]) |=> ready_irq)
      else $error("ready interrupt missing");

   chk_window_expires: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (state_reg == ST_ARMED && win_cnt_reg == 3'h4 && !cpu_req.store)
      ##1 (!cpu_req.store && !ctrl_wr && !cpu_req.load) [*3]
      |=> cmd_reg == 5'h00)
      else $error("command window did not expire");

   chk_illegal_ignored: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (ctrl_wr && !cmd_legal(wr_cmd) && state_reg == ST_IDLE)
      |=> state_reg == ST_IDLE)
      else $error("illegal command acted on");

   chk_busy_on_section: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (store_go && (cmd_reg == CMD_ERASE || cmd_reg == CMD_WRITE) &&
       req_page < HALT_PAGE)
      |=> section_read_block && flash_start && !cpu_stall)
      else $error("section busy not set");

   chk_stall_held: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (cpu_stall && !flash_done) |=> cpu_stall && cmd_reg[0])
      else $error("stall dropped early");

   chk_page_latched: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (state_reg == ST_BUSY && !flash_start) |-> $stable(flash_page))
      else $error("page changed during operation");

   chk_reen_refused: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (state_reg == ST_BUSY && ctrl_wr && !flash_done)
      |=> state_reg == ST_BUSY)
      else $error("command accepted while busy");

   chk_load_clears: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (store_go && cmd_reg == CMD_LOAD) |=> !section_read_block)
      else $error("busy not cleared by load");

   chk_avs_one_wait: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (avs_read && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer timing wrong");

   cov_erase: cover property (@(posedge core_clk) disable iff (!rstn)
      store_go && cmd_reg == CMD_ERASE);
   cov_lock_read: cover property (@(posedge core_clk) disable iff (!rstn)
      load_go);
   cov_timeout: cover property (@(posedge core_clk) disable iff (!rstn)
      state_reg == ST_ARMED && win_cnt_reg == 3'h1 && !store_go);

endmodule

`default_nettype wire

// File: rtl/spm_ctrl_pkg.sv
// ----------------------------------------------------------------
// Shared constants and carriers for the self-programming control
// ----------------------------------------------------------------
package self_prog_pkg;

   // Register byte offsets
   localparam logic [3:0] CTRL_OFFSET      = 4'h0;  // Control and status
   localparam logic [3:0] LOCK_OFFSET      = 4'h4;  // Lock bits view

   // Control register field positions
   localparam int IRQ_EN_BIT       = 7;  // Ready interrupt enable
   localparam int BUSY_BIT         = 6;  // Section busy flag
   localparam int RSVD_BIT         = 5;  // Reserved, reads zero
   localparam int REEN_BIT         = 4;  // Section read re-enable
   localparam int LOCK_BIT         = 3;  // Lock set
   localparam int PGWR_BIT         = 2;  // Page write
   localparam int PGER_BIT         = 1;  // Page erase
   localparam int CMDEN_BIT        = 0;  // Command enable

   // Reset values
   localparam logic [7:0] CTRL_RESET       = 8'h00;
   localparam logic [7:0] LOCK_RESET       = 8'hFF;  // All unprogrammed
   localparam logic [15:0] BUF_ERASED      = 16'hFFFF;

   // Legal command codes in the lower five bits
   localparam logic [4:0] CMD_LOAD         = 5'h01;  // 00001
   localparam logic [4:0] CMD_ERASE        = 5'h03;  // 00011
   localparam logic [4:0] CMD_WRITE        = 5'h05;  // 00101
   localparam logic [4:0] CMD_LOCK         = 5'h09;  // 01001
   localparam logic [4:0] CMD_REEN         = 5'h11;  // 10001

   // Command windows in cycles
   localparam logic [2:0] STORE_WINDOW     = 3'h4;   // Four cycles
   localparam logic [2:0] LOAD_WINDOW      = 3'h3;   // Three cycles

   // Lock byte: only bits 5..2 can be programmed by software
   localparam logic [7:0] LOCK_WR_MASK     = 8'h3C;

   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,  // No command pending
      ST_ARMED = 2'b01,  // Window open for a store or load
      ST_BUSY  = 2'b10   // Erase or write running in the array
   } seq_state_t;

   // Processor-side instruction request
   typedef struct packed {
      logic        store;     // Store-program instruction, one cycle
      logic        load;      // Load-program instruction, one cycle
      logic [7:0]  page_ext;  // Page extension register
      logic [15:0] zptr;      // Address pointer
      logic [7:0]  r1;        // High data register
      logic [7:0]  r0;        // Low data register
   } cpu_req_t;

   // Fuse bytes as read from the fuse array
   typedef struct packed {
      logic [7:0] ext;   // Extended fuse byte
      logic [7:0] high;  // High fuse byte
      logic [7:0] low;   // Low fuse byte
   } fuse_bits_t;

endpackage

// File: bench/flash_array_model.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------
// Flash array: ends each erase or write late
// ------------------------------------------
module flash_array_model (
   input  wire logic       core_clk,
   input  wire logic       rstn,
   input  wire logic       flash_start,
   input  wire logic [7:0] lat,
   output logic            flash_done
);
   logic [7:0] cnt_reg;  // Cycles left, zero when idle
   // Count down from each start, pulse done on the last cycle
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= 8'h00;
         flash_done <= 1'b0;
      end else begin
         flash_done <= (cnt_reg == 8'h01);
         if (flash_start) begin
            cnt_reg <= lat;
         end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// File: bench/flash_self_program_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module flash_self_program_control_tb
   import self_prog_pkg::*;
;
   logic        core_clk = 1'b0, rstn = 1'b0, avs_read = 1'b0;
   logic        avs_write = 1'b0, gflag = 1'b1, fuse = 1'b1;
   logic [3:0]  avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, rd, avs_readdata;
   logic        avs_waitrequest, load_valid, cpu_stall, ready_irq;
   logic        section_read_block, flash_done, flash_start, flash_erase;
   logic [7:0]  load_data, exp_b;
   logic [15:0] reset_vector, buf_rd_data;
   logic [8:0]  flash_page;
   cpu_req_t    cpu_req = '0;
   fuse_bits_t  fuse_bits = 24'hE1D2B4;  // Ext, high, low
   int          failures = 0, total_checks = 0;

   always #20 core_clk = ~core_clk;  // 25 MHz

   flash_self_program_control uut (.core_clk, .rstn, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'h1),
      .avs_readdata, .avs_waitrequest, .cpu_req, .global_irq_flag(gflag),
      .boot_reset_fuse(fuse), .fuse_bits, .flash_rd_word(16'h9A5B),
      .load_data, .load_valid, .cpu_stall, .ready_irq, .section_read_block,
      .reset_vector, .flash_done, .buf_rd_idx(7'h02), .buf_rd_data,
      .flash_start, .flash_erase, .flash_page);
   flash_array_model partner (.core_clk, .rstn, .flash_start,
      .lat(8'h14), .flash_done);

   // ------------------------------------------
   // Shared tasks
   // ------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Avalon transfer held until waitrequest low, then one idle edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0) @(posedge core_clk);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge core_clk);
   endtask
   // One store or load pulse, then one edge so its results stand
   task automatic cpu_op(input logic [15:0] z, input logic [7:0] e,
                         input logic [15:0] d, input logic ld);
      cpu_req.zptr <= z;
      cpu_req.page_ext <= e;
      {cpu_req.r1, cpu_req.r0} <= d;
      cpu_req.store <= !ld;
      cpu_req.load <= ld;
      @(posedge core_clk);
      cpu_req.store <= 1'b0;
      cpu_req.load <= 1'b0;
      @(posedge core_clk);
   endtask
   // Poll until command enable drops
   task automatic wait_idle;
      do bus(1'b0, CTRL_OFFSET, 8'h00); while (rd[CMDEN_BIT] !== 1'b0);
   endtask
   task automatic results;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (5000) @(posedge core_clk);
      failures++;
      results();
   end

   // ------------------------------------------
   // Main sequence
   // ------------------------------------------
   initial begin
      repeat (6) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk("vector", 32'h0, {16'h0, reset_vector});
      bus(1'b0, CTRL_OFFSET, 8'h00);
      chk("ctrl_rst", {24'h0, CTRL_RESET}, rd);
      bus(1'b1, CTRL_OFFSET, 8'hE2);
      bus(1'b0, CTRL_OFFSET, 8'h00);
      chk("ctrl_bad", 32'h80, rd);
      chk("irq", 1'b1, ready_irq);
      bus(1'b1, CTRL_OFFSET, 8'h81);
      cpu_op(16'h0005, 8'h00, 16'hA53C, 1'b0);
      bus(1'b0, CTRL_OFFSET, 8'h00);
      chk("ctrl_ld", 32'h80, rd);
      chk("buf", 16'hA53C, buf_rd_data);
      bus(1'b1, CTRL_OFFSET, 8'h91);
      @(posedge core_clk);
      chk("buf_drop", BUF_ERASED, buf_rd_data);
      bus(1'b1, CTRL_OFFSET, 8'h83);
      cpu_op(16'h0500, 8'h00, 16'h1234, 1'b0);
      chk("erase", 3'b111, {flash_start, flash_erase, flash_page == 9'h005});
      cpu_req.zptr <= 16'hFF00;
      bus(1'b1, CTRL_OFFSET, 8'h91);
      chk("busy", 32'hC3, rd);
      chk("blk", 2'b10, {section_read_block, cpu_stall});
      chk("latch", 9'h005, flash_page);
      wait_idle();
      chk("done", 32'hC0, rd);
      bus(1'b1, CTRL_OFFSET, 8'h91);
      cpu_op(16'h0000, 8'h00, 16'h0000, 1'b0);
      bus(1'b0, CTRL_OFFSET, 8'h00);
      chk("reen", 32'h80, rd);
      bus(1'b1, CTRL_OFFSET, 8'h81);
      cpu_op(16'h0004, 8'h00, 16'h5A5A, 1'b0);
      bus(1'b1, CTRL_OFFSET, 8'h83);
      cpu_op(16'hE000, 8'h01, 16'h0000, 1'b0);
      wait_idle();
      bus(1'b1, CTRL_OFFSET, 8'h85);
      cpu_op(16'hE000, 8'h01, 16'h0000, 1'b0);
      chk("write", 2'b10, {flash_start, flash_erase});
      chk("wpage", 9'h1E0, flash_page);
      @(posedge core_clk);
      chk("stall", 2'b10, {cpu_stall, ready_irq});
      wait_idle();
      chk("unstall", 1'b0, cpu_stall);
      chk("buf_clr", BUF_ERASED, buf_rd_data);
      bus(1'b1, CTRL_OFFSET, 8'h89);
      cpu_op(16'h0001, 8'h00, 16'hFFC3, 1'b0);
      for (int i = 0; i < 4; i++) begin
         exp_b = (i == 0) ? 8'hB4 : (i == 1) ? 8'hC3 : (i == 2) ? 8'hE1 : 8'hD2;
         bus(1'b1, CTRL_OFFSET, 8'h89);
         cpu_op(i[15:0], 8'h00, 16'h0000, 1'b1);
         chk("lockfuse", {1'b1, exp_b}, {load_valid, load_data});
      end
      cpu_op(16'h0001, 8'h00, 16'h0000, 1'b1);
      chk("plain", 8'h9A, load_data);
      bus(1'b0, LOCK_OFFSET, 8'h00);
      chk("lockview", 32'hC3, rd);
      bus(1'b1, CTRL_OFFSET, 8'h81);
      repeat (5) @(posedge core_clk);
      bus(1'b0, CTRL_OFFSET, 8'h00);
      chk("tmo", 32'h80, rd);
      bus(1'b0, 4'hC, 8'h00);
      chk("unmap", 32'h0, rd);
      fuse <= 1'b0;
      rstn <= 1'b0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk("bootvec", 16'hF000, reset_vector);
      results();
   end
endmodule
`default_nettype wire
